// File: common/ivpf_defines.svh
// Constants for the isochronous video packet framer
`ifndef IVPF_DEFINES_SVH
`define IVPF_DEFINES_SVH
`define IVPF_TAG_VALUE 2'h0
`define IVPF_TCODE_ISO 4'ha
`define IVPF_SYNC_FIRST 4'h1
`define IVPF_SYNC_LATER 4'h0
`define IVPF_BYTES_PER_QUAD_SHIFT 2
`define IVPF_CHAN_RESET 6'h00
`define IVPF_CRC_INIT 32'hffffffff
`define IVPF_CRC_POLY 32'h04c11db7
`endif

// File: common/ivpf_pkg.sv
// Types for the isochronous video packet framer
package ivpf_pkg;
  typedef enum logic [2:0] {
    IVPF_IDLE,
    IVPF_HDR,
    IVPF_HCRC,
    IVPF_PAY,
    IVPF_DCRC,
    IVPF_WAIT
  } ivpf_state_t;
  typedef logic [2:0] ivpf_sel_t;
  typedef logic [5:0] ivpf_speed_t;
endpackage : ivpf_pkg

// File: design/ivpf_mode_table.sv
// Payload size lookup by format, mode and frame rate
`timescale 1ns/1ps
`default_nettype none
`include "ivpf_defines.svh"
module ivpf_mode_table (
  input wire logic [1:0] fmt, // Format index 0..2
  input wire logic [2:0] mode, // Mode within format
  input wire logic [2:0] rate, // 0=240fps .. 7=1.875fps
  output logic valid, // Combination has an entry
  output logic [13:0] quads, // Quadlets per packet
  output logic [5:0] speed, // Minimum speed prefix
  output logic [7:0] lines_x16, // Lines per packet, times 16, held at 255 when larger
  output logic [15:0] pixels // Pixels per packet
);
  import ivpf_pkg::*;
  logic [2:0] lo;
  logic [2:0] hi;
  logic [13:0] qb;
  logic [15:0] pb;
  logic [8:0] lb;
  logic [5:0] top;
  logic [2:0] shift;
  logic [8:0] lines;

  // Entry values at the fastest legal rate; lo..hi is the span of rates that exist
  always_comb begin
    {lo, hi, qb, pb, lb} = {3'h7, 3'h0, 14'd0, 16'd0, 9'd0};
    unique case ({fmt, mode})
      5'h06: {lo, hi, qb, pb, lb} = {3'h0, 3'h7, 14'd5120, 16'd10240, 9'd256}; // 640 mono16
      5'h08: {lo, hi, qb, pb, lb} = {3'h0, 3'h6, 14'd8000, 16'd16000, 9'd320}; // 800 yuv
      5'h09: {lo, hi, qb, pb, lb} = {3'h1, 3'h5, 14'd6000, 16'd8000, 9'd160}; // 800 rgb
      5'h0a: {lo, hi, qb, pb, lb} = {3'h0, 3'h5, 14'd4000, 16'd16000, 9'd320}; // 800 mono8
      5'h0b: {lo, hi, qb, pb, lb} = {3'h1, 3'h7, 14'd6144, 16'd12288, 9'd192}; // 1024 yuv
      5'h0c: {lo, hi, qb, pb, lb} = {3'h2, 3'h7, 14'd4608, 16'd6144, 9'd96}; // 1024 rgb
      5'h0d: {lo, hi, qb, pb, lb} = {3'h0, 3'h7, 14'd6144, 16'd24576, 9'd384}; // 1024 mono8
      5'h0e: {lo, hi, qb, pb, lb} = {3'h0, 3'h6, 14'd8000, 16'd16000, 9'd320}; // 800 mono16
      5'h0f: {lo, hi, qb, pb, lb} = {3'h1, 3'h7, 14'd6144, 16'd12288, 9'd192}; // 1024 mono16
      5'h10: {lo, hi, qb, pb, lb} = {3'h2, 3'h7, 14'd5120, 16'd10240, 9'd128}; // 1280 yuv
      5'h11: {lo, hi, qb, pb, lb} = {3'h2, 3'h7, 14'd7680, 16'd10240, 9'd128}; // 1280 rgb
      5'h12: {lo, hi, qb, pb, lb} = {3'h1, 3'h7, 14'd5120, 16'd20480, 9'd256}; // 1280 mono8
      5'h13: {lo, hi, qb, pb, lb} = {3'h2, 3'h7, 14'd8000, 16'd16000, 9'd160}; // 1600 yuv
      5'h14: {lo, hi, qb, pb, lb} = {3'h3, 3'h7, 14'd6000, 16'd8000, 9'd80}; // 1600 rgb
      5'h15: {lo, hi, qb, pb, lb} = {3'h1, 3'h7, 14'd8000, 16'd32000, 9'd320}; // 1600 mono8
      5'h16: {lo, hi, qb, pb, lb} = {3'h2, 3'h7, 14'd5120, 16'd10240, 9'd128}; // 1280 mono16
      5'h17: {lo, hi, qb, pb, lb} = {3'h2, 3'h7, 14'd8000, 16'd16000, 9'd160}; // 1600 mono16
      default: ;
    endcase
  end

  // Each slower rate halves; rates outside the span have no entry
  always_comb begin
    top = ({fmt, mode} == 5'h0a) ? 6'h10 : 6'h20;
    valid = (rate >= lo) && (rate <= hi);
    shift = rate - lo;
    quads = qb >> shift;
    pixels = pb >> shift;
    lines = lb >> shift;
    lines_x16 = (lines > 9'd255) ? 8'hff : lines[7:0];
    // Below a prefix of 2 no minimum speed is demanded
    speed = top >> shift;
    if (!valid || speed < 6'h2) begin
      speed = 6'h0;
    end
  end
endmodule : ivpf_mode_table
`default_nettype wire

// File: design/ivpf_framer.sv
// Isochronous video packet framer top
`timescale 1ns/1ps
`default_nettype none
`include "ivpf_defines.svh"
// Contract
// - The header length field carries the byte count of the block's data field.
// - The tag field is always zero.
// - The channel field carries the software-programmed channel number.
// - The transaction code is the isochronous data block code.
// - Sync is 1 on a frame's first block and 0 on later blocks.
// - Header quadlet, then header CRC, then payload, then data CRC.
// - Payload holds only current-frame video data.
// - Byte length is quadlets per packet times four.
// - Speed prefix 2/4/8/16/32 names the minimum link speed S200..S3200.
module ivpf_framer #(
  parameter int LINES_PER_FRAME = 480
) (
  input wire logic SYS_CLK, // 200 MHz clock
  input wire logic ARST_N, // Async reset, low active
  input wire logic [5:0] ISO_CHANNEL, // Programmed channel number
  input wire logic [1:0] VID_FORMAT, // Format index
  input wire logic [2:0] VID_MODE, // Mode index
  input wire logic [2:0] VID_RATE, // Frame rate index
  input wire logic START, // Begin a frame, pulse
  input wire logic CYCLE_START, // Bus cycle start, pulse
  input wire logic [31:0] PIX_DATA, // Video quadlet
  input wire logic PIX_VALID, // Video quadlet valid
  output logic PIX_READY, // Video quadlet taken
  output logic [31:0] TX_DATA, // Outgoing quadlet
  output logic TX_VALID, // Outgoing quadlet valid
  output logic TX_LAST, // Last quadlet of block
  output logic [5:0] TX_SPEED, // Minimum speed prefix
  output logic BUSY, // Frame in progress
  output logic CFG_ERR // Combination refused
);
  import ivpf_pkg::*;

  // ==========
  // Parameter check
  // A frame needs one line at least; the quadlet total must fit the 32-bit down counter
  if (LINES_PER_FRAME < 1 || LINES_PER_FRAME > 65535) begin : g_bad_lines
    $error("LINES_PER_FRAME out of range");
  end

  // ==========
  // Frame state
  // Whole state in one packed word so that a single register holds it

  typedef struct packed {
    ivpf_state_t st;
    logic [13:0] quads;
    logic [13:0] qcnt;
    logic [31:0] pix_left;
    logic [31:0] crc;
    logic first;
    logic [5:0] chan;
    logic pix_ready;
    logic [31:0] tx_data;
    logic tx_valid;
    logic tx_last;
    logic [5:0] speed;
    logic busy;
    logic err;
  } ivpf_regs_t;

  ivpf_regs_t q_reg, q_next;
  logic tv_valid;
  logic [13:0] tv_quads;
  logic [5:0] tv_speed;
  logic [15:0] tv_pixels;

  // ==========
  // Size lookup
  // Size lookup shared by every block of the frame
  ivpf_mode_table u_tab (
    .fmt(VID_FORMAT),
    .mode(VID_MODE),
    .rate(VID_RATE),
    .valid(tv_valid),
    .quads(tv_quads),
    .speed(tv_speed),
    .lines_x16(),
    .pixels(tv_pixels)
  );

  // ==========
  // Helper functions
  // Quadlets in a whole frame; widened first so the product cannot wrap
  function automatic logic [31:0] ivpf_frame_quads(input logic [13:0] qd);
    logic [31:0] total;
    total = 32'(LINES_PER_FRAME) * 32'(qd);
    return total;
  endfunction : ivpf_frame_quads

  // CRC-32 over one quadlet, bit serial unrolled
  function automatic logic [31:0] ivpf_crc(input logic [31:0] c, input logic [31:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 31; i >= 0; i--) begin
      r = (r[31] ^ d[i]) ? ((r << 1) ^ `IVPF_CRC_POLY) : (r << 1);
    end
    return r;
  endfunction : ivpf_crc

  // Header quadlet assembly
  function automatic logic [31:0] ivpf_hdr(input logic [13:0] qd, input logic [5:0] ch,
                                          input logic fst);
    logic [15:0] len;
    // Quadlets to bytes; 14 bits of quadlets always fit the 16-bit length
    len = 16'({2'b00, qd} << `IVPF_BYTES_PER_QUAD_SHIFT);
    return {len, `IVPF_TAG_VALUE, ch, `IVPF_TCODE_ISO,
            fst ? `IVPF_SYNC_FIRST : `IVPF_SYNC_LATER};
  endfunction : ivpf_hdr

  // ==========
  // Next-state logic
  // Strobes default low so that each output pulse stands for one cycle only
  always_comb begin
    q_next = q_reg;
    q_next.tx_valid = 1'b0;
    q_next.tx_last = 1'b0;
    q_next.pix_ready = 1'b0;
    unique case (q_reg.st)
      IVPF_IDLE: begin
        // Sizes and channel are latched here; later changes wait for the next frame
        if (START) begin
          q_next.err = !tv_valid;
          if (tv_valid) begin
            q_next.quads = tv_quads;
            q_next.speed = tv_speed;
            q_next.chan = ISO_CHANNEL;
            // Frame size counted in quadlets, one per payload word taken
            q_next.pix_left = ivpf_frame_quads(tv_quads);
            q_next.first = 1'b1;
            q_next.busy = 1'b1;
            q_next.st = IVPF_WAIT;
          end
        end
      end
      IVPF_WAIT: begin
        // One block per bus cycle
        if (CYCLE_START) begin
          q_next.st = IVPF_HDR;
        end
      end
      IVPF_HDR: begin
        // Header CRC starts fresh on the header quadlet alone
        q_next.tx_data = ivpf_hdr(q_reg.quads, q_reg.chan, q_reg.first);
        q_next.tx_valid = 1'b1;
        q_next.crc = ivpf_crc(`IVPF_CRC_INIT, q_next.tx_data);
        q_next.st = IVPF_HCRC;
      end
      IVPF_HCRC: begin
        // Data CRC restarts; only the first block of a frame carries sync set
        q_next.tx_data = ~q_reg.crc;
        q_next.tx_valid = 1'b1;
        q_next.crc = `IVPF_CRC_INIT;
        q_next.qcnt = q_reg.quads;
        q_next.first = 1'b0;
        q_next.st = IVPF_PAY;
      end
      IVPF_PAY: begin
        // Only frame video quadlets enter the payload
        q_next.pix_ready = (q_reg.qcnt > 14'h1) || !q_reg.pix_ready;
        if (PIX_VALID && q_reg.pix_ready) begin
          q_next.tx_data = PIX_DATA;
          q_next.tx_valid = 1'b1;
          q_next.crc = ivpf_crc(q_reg.crc, PIX_DATA);
          q_next.qcnt = q_reg.qcnt - 14'h1;
          q_next.pix_left = q_reg.pix_left - 32'h1;
          if (q_reg.qcnt == 14'h1) begin
            q_next.pix_ready = 1'b0;
            q_next.st = IVPF_DCRC;
          end
        end
      end
      IVPF_DCRC: begin
        // A stalled source only delays the block; the bus cycle budget is the user's limit
        q_next.tx_data = ~q_reg.crc;
        q_next.tx_valid = 1'b1;
        q_next.tx_last = 1'b1;
        // Continue until every quadlet of the frame is out
        if (q_reg.pix_left == 32'h0) begin
          q_next.busy = 1'b0;
          q_next.st = IVPF_IDLE;
        end else begin
          q_next.st = IVPF_WAIT;
        end
      end
      default: q_next.st = IVPF_IDLE;
    endcase
  end

  // ==========
  // State register
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      q_reg <= '{st: IVPF_IDLE, chan: `IVPF_CHAN_RESET, crc: `IVPF_CRC_INIT, default: '0};
    end else begin
      q_reg <= q_next;
    end
  end

  // ==========
  // Outputs
  // Every output is a field of the state register
  assign PIX_READY = q_reg.pix_ready;
  assign TX_DATA = q_reg.tx_data;
  assign TX_VALID = q_reg.tx_valid;
  assign TX_LAST = q_reg.tx_last;
  assign TX_SPEED = q_reg.speed;
  assign BUSY = q_reg.busy;
  assign CFG_ERR = q_reg.err;
endmodule : ivpf_framer
`default_nettype wire

// File: bench/ivpf_framer_monitor.sv
// Output checker for the packet framer
`timescale 1ns/1ps
`default_nettype none
module ivpf_framer_monitor (
  input wire logic SYS_CLK, // Clock
  input wire logic ARST_N, // Reset, low active
  input wire logic [5:0] ISO_CHANNEL, // Channel
  input wire logic START, // Frame start
  input wire logic CYCLE_START, // Bus cycle
  input wire logic [31:0] TX_DATA, // Quadlet
  input wire logic TX_VALID, // Quadlet valid
  input wire logic TX_LAST, // Block end
  input wire logic [5:0] TX_SPEED, // Speed prefix
  input wire logic BUSY, // Frame busy
  input wire logic CFG_ERR // Refused
);
  // ==========
  // Block tracking
  logic in_reg;
  logic first_reg;
  logic [5:0] chan_reg;
  logic [13:0] cnt_reg;
  logic [15:0] len_reg;
  wire hdr = TX_VALID && !in_reg;
  // A start taken only when idle, as the framer ignores it otherwise
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      in_reg <= 1'b0;
      first_reg <= 1'b0;
      chan_reg <= 6'h00;
      cnt_reg <= 14'h0;
      len_reg <= 16'h0;
    end else begin
      if (START && !BUSY) begin
        first_reg <= 1'b1;
        chan_reg <= ISO_CHANNEL;
      end else if (hdr) begin
        first_reg <= 1'b0;
      end
      if (hdr) len_reg <= TX_DATA[31:16];
      if (TX_VALID) in_reg <= !TX_LAST;
      if (TX_VALID) cnt_reg <= TX_LAST ? 14'h0 : cnt_reg + 14'h1;
    end
  end
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!ARST_N);
  a_hdr_tag: assert property (hdr |-> TX_DATA[15:14] == 2'h0)
    else $error("tag not zero");
  a_hdr_chan: assert property (hdr |-> TX_DATA[13:8] == chan_reg)
    else $error("channel wrong");
  a_hdr_tcode: assert property (hdr |-> TX_DATA[7:4] == 4'ha)
    else $error("tcode wrong");
  a_hdr_sync: assert property (hdr |-> TX_DATA[3:0] == {3'h0, first_reg})
    else $error("sync wrong");
  a_len_quads: assert property (hdr |-> TX_DATA[17:16] == 2'h0)
    else $error("length not whole quadlets");
  a_blk_len: assert property (TX_LAST |-> {cnt_reg, 2'h0} == len_reg + 16'h8)
    else $error("block length mismatch");
  a_last_valid: assert property (TX_LAST |-> TX_VALID)
    else $error("last without valid");
  a_cycle_hdr: assert property (CYCLE_START && BUSY && !in_reg |-> ##2 hdr)
    else $error("no header after cycle start");
  a_err_idle: assert property (CFG_ERR |-> !BUSY)
    else $error("busy after refusal");
  a_speed_code: assert property (TX_VALID |-> TX_SPEED inside {2, 4, 8, 16, 32})
    else $error("bad speed prefix");
endmodule : ivpf_framer_monitor
bind ivpf_framer ivpf_framer_monitor u_mon (.*);
`default_nettype wire

// File: bench/ivpf_link_model.sv
// Link side model: bus cycles and block capture
`timescale 1ns/1ps
`default_nettype none
module ivpf_link_model #(
  parameter int PERIOD = 800
) (
  input wire logic clk, // Clock
  input wire logic arst_n, // Reset, low active
  input wire logic clr, // Clear capture
  input wire logic [31:0] tx_data, // Quadlet
  input wire logic tx_valid, // Quadlet valid
  input wire logic tx_last, // Block end
  input wire logic [5:0] tx_speed, // Speed prefix
  output logic cyc_start, // Bus cycle pulse
  output logic [15:0] blocks, // Blocks seen
  output logic [31:0] hdr_a, // First header
  output logic [31:0] hdr_b, // Latest header
  output logic [31:0] first_pay, // First payload
  output logic [5:0] spd // Speed at header
);
  int tick = 0;
  logic [15:0] idx = 16'h0;
  // ==========
  // One cycle start per period, off the sampling edge
  always @(negedge clk) begin
    tick <= (tick == PERIOD - 1) ? 0 : tick + 1;
    cyc_start <= arst_n && tick == PERIOD - 1;
  end
  // Capture by quadlet index within the block
  always @(posedge clk) begin
    if (clr) begin
      blocks <= 16'h0;
      idx <= 16'h0;
    end else if (tx_valid) begin
      idx <= tx_last ? 16'h0 : idx + 16'h1;
      if (idx == 0 && blocks == 0) hdr_a <= tx_data;
      if (idx == 0) hdr_b <= tx_data;
      if (idx == 0) spd <= tx_speed;
      if (idx == 2 && blocks == 0) first_pay <= tx_data;
      if (tx_last) blocks <= blocks + 16'h1;
    end
  end
endmodule : ivpf_link_model
`default_nettype wire

// File: bench/ivpf_framer_tb.sv
// Testbench for the packet framer
`timescale 1ns/1ps
`default_nettype none
module ivpf_framer_tb;
  logic SYS_CLK = 1'b0, ARST_N = 1'b0, START = 1'b0, PIX_VALID = 1'b0, clr = 1'b1;
  logic [5:0] ISO_CHANNEL = 6'h00;
  logic [1:0] VID_FORMAT = 2'h0;
  logic [2:0] VID_MODE = 3'h0, VID_RATE = 3'h0;
  logic [31:0] PIX_DATA = 32'h0, pix_cnt = 32'h0, hdr_a, hdr_b, first_pay, TX_DATA;
  logic CYCLE_START, PIX_READY, TX_VALID, TX_LAST, BUSY, CFG_ERR;
  logic [5:0] TX_SPEED, spd;
  logic [15:0] blocks;
  int error_cnt = 0, compares = 0;
  ivpf_framer #(.LINES_PER_FRAME(2)) dut (.SYS_CLK(SYS_CLK), .ARST_N(ARST_N),
    .ISO_CHANNEL(ISO_CHANNEL), .VID_FORMAT(VID_FORMAT), .VID_MODE(VID_MODE),
    .VID_RATE(VID_RATE), .START(START), .CYCLE_START(CYCLE_START), .PIX_DATA(PIX_DATA),
    .PIX_VALID(PIX_VALID), .PIX_READY(PIX_READY), .TX_DATA(TX_DATA), .TX_VALID(TX_VALID),
    .TX_LAST(TX_LAST), .TX_SPEED(TX_SPEED), .BUSY(BUSY), .CFG_ERR(CFG_ERR));
  ivpf_link_model #(.PERIOD(800)) link (.clk(SYS_CLK), .arst_n(ARST_N), .clr(clr),
    .tx_data(TX_DATA), .tx_valid(TX_VALID), .tx_last(TX_LAST), .tx_speed(TX_SPEED),
    .cyc_start(CYCLE_START), .blocks(blocks), .hdr_a(hdr_a), .hdr_b(hdr_b),
    .first_pay(first_pay), .spd(spd));
  // ==========
  // Clock and video source; data moves only on the falling edge
  always #2.5 SYS_CLK = ~SYS_CLK;
  always @(posedge SYS_CLK) if (PIX_VALID && PIX_READY) pix_cnt <= pix_cnt + 32'h1;
  always @(negedge SYS_CLK) PIX_DATA <= 32'h5a000000 + pix_cnt;
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task complete_run;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run
  task start_frame(input logic [5:0] ch, input logic [2:0] m, input logic [2:0] r);
    @(negedge SYS_CLK);
    {ISO_CHANNEL, VID_FORMAT, VID_MODE, VID_RATE, START, clr} = {ch, 2'h2, m, r, 2'b11};
    @(negedge SYS_CLK);
    {START, clr} = 2'b00;
  endtask : start_frame
  // Rate outside the mode's span has no entry and must be refused
  task t_refuse;
    start_frame(6'h11, 3'h0, 3'h0);
    check("cfg_err", {31'h0, CFG_ERR}, 32'h1);
    check("busy", {31'h0, BUSY}, 32'h0);
  endtask : t_refuse
  // Whole frame, with a second start mid-frame that must be ignored
  task t_frame(input logic [5:0] ch, input logic [2:0] m, input logic [2:0] r,
               input logic [13:0] q, input logic [5:0] sp);
    logic [31:0] base;
    int n;
    base = pix_cnt;
    start_frame(ch, m, r);
    check("busy", {31'h0, BUSY}, 32'h1);
    @(negedge SYS_CLK);
    ISO_CHANNEL = ~ch;
    START = 1'b1;
    @(negedge SYS_CLK);
    START = 1'b0;
    for (n = 0; n < 20000 && BUSY !== 1'b0; n++) @(negedge SYS_CLK);
    // The last data CRC reaches the link one edge after busy falls
    @(negedge SYS_CLK);
    check("blocks", {16'h0, blocks}, 32'h2);
    check("hdr first", hdr_a, {q, 2'h0, 2'h0, ch, 4'ha, 4'h1});
    check("hdr later", hdr_b, {q, 2'h0, 2'h0, ch, 4'ha, 4'h0});
    check("payload", first_pay, 32'h5a000000 + base);
    check("taken", pix_cnt - base, {17'h0, q, 1'b0});
    check("speed", {26'h0, spd}, {26'h0, sp});
  endtask : t_frame
  initial begin
    repeat (3) @(negedge SYS_CLK);
    ARST_N = 1'b1;
    PIX_VALID = 1'b1;
    t_refuse();
    t_frame(6'h2a, 3'h2, 3'h4, 14'd640, 6'd4);
    t_frame(6'h05, 3'h4, 3'h6, 14'd750, 6'd4);
    complete_run();
  end
  // Watchdog well past the expected run
  initial begin
    #100000;
    error_cnt++;
    complete_run();
  end
endmodule : ivpf_framer_tb
`default_nettype wire
